/* File: hw/mcuex_map.svh */
// Constants for the instruction execute tail: register offsets, field
// positions, reset values and cycle counts.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef MCUEX_MAP_SVH
`define MCUEX_MAP_SVH

// Register offsets on the plain register port
`define MCUEX_OFS_CTRL       8'h00
`define MCUEX_OFS_FLAGS      8'h01
`define MCUEX_OFS_ACC        8'h02
`define MCUEX_OFS_PC_LO      8'h03
`define MCUEX_OFS_PC_HI      8'h04

// Control register fields
`define MCUEX_CTRL_PAGE_LSB  0
`define MCUEX_CTRL_PAGE_MSB  1
`define MCUEX_CTRL_GIE_BIT   2

// Flag register fields
`define MCUEX_FLAG_C_BIT     0
`define MCUEX_FLAG_DC_BIT    1
`define MCUEX_FLAG_Z_BIT     2
`define MCUEX_FLAG_PD_BIT    4
`define MCUEX_FLAG_TO_BIT    5

// Reset values
`define MCUEX_RST_BYTE       8'h00
`define MCUEX_RST_PC         16'h0000
`define MCUEX_RST_PAGE       2'h0

// Extra cycles beyond the first
`define MCUEX_EXTRA_BRANCH   2'h1
`define MCUEX_EXTRA_NONE     2'h0

`endif

/* File: hw/mcuex_pkg.sv */
// Types shared by the execute tail core and its ALU.
// Assumes nothing of its surroundings.
package mcuex_pkg;

  typedef enum logic [5:0] {
    op_nop,
    op_or_acc_mem,
    op_or_mem_acc,
    op_or_acc_imm,
    op_xor_acc_mem,
    op_xor_mem_acc,
    op_xor_acc_imm,
    op_nibble_exchange_op,
    op_nibble_exchange_in_place_op,
    op_rotate_right_op,
    op_rotate_right_in_place_op,
    op_rotate_left_op,
    op_rotate_left_in_place_op,
    op_clear_op,
    op_bit_clear_op,
    op_bit_set_op,
    op_bank0_bit_clear_op,
    op_bank0_bit_set_op,
    op_compare_skip_imm,
    op_compare_skip_mem,
    op_increment_skip_op,
    op_increment_memory_skip_op,
    op_decrement_skip_op,
    op_decrement_memory_skip_op,
    op_bit_zero_skip_op,
    op_bit_one_skip_op,
    op_bank0_bit_zero_skip_op,
    op_bank0_bit_one_skip_op,
    op_jump,
    op_call,
    op_return,
    op_interrupt_return_op,
    op_push,
    op_pop
  } mcuex_op_t;

endpackage

/* File: hw/mcuex_alu_if.sv */
// Carrier between the execute core and its combinational ALU.
// Assumes both ends share one clock domain; no storage inside.
`timescale 1ns/1ps
interface mcuex_alu_if;
  mcuex_pkg::mcuex_op_t op;
  logic [7:0]           acc;
  logic [7:0]           mem;
  logic [7:0]           imm;
  logic [2:0]           bit_sel;
  logic                 carry;
  logic [7:0]           result;
  logic                 c_out;
  logic                 z_out;
  logic                 c_we;
  logic                 z_we;
  logic                 to_acc;
  logic                 to_mem;
  logic                 skip;

  modport core (
    output op, acc, mem, imm, bit_sel, carry,
    input  result, c_out, z_out, c_we, z_we, to_acc, to_mem, skip
  );
  modport alu (
    input  op, acc, mem, imm, bit_sel, carry,
    output result, c_out, z_out, c_we, z_we, to_acc, to_mem, skip
  );
endinterface

/* File: hw/mcuex_alu.sv */
// Combinational data path of the execute tail: result, flags, skip.
// Assumes the core registers every output it takes from here.
`timescale 1ns/1ps
module mcuex_alu (
  mcuex_alu_if.alu bus
);

  logic [7:0] src;
  logic [8:0] diff;
  logic [7:0] mask;

  always_comb begin
    src  = (bus.op == mcuex_pkg::op_or_acc_imm ||
            bus.op == mcuex_pkg::op_xor_acc_imm ||
            bus.op == mcuex_pkg::op_compare_skip_imm) ? bus.imm : bus.mem;
    diff = {1'b0, bus.acc} - {1'b0, src};
    mask = 8'h01 << bus.bit_sel;
  end

  always_comb begin
    bus.result = bus.acc;
    bus.c_out  = bus.carry;
    bus.c_we   = 1'b0;
    bus.z_we   = 1'b0;
    bus.to_acc = 1'b0;
    bus.to_mem = 1'b0;
    bus.skip   = 1'b0;
    case (bus.op)
      mcuex_pkg::op_or_acc_mem, mcuex_pkg::op_or_acc_imm: begin
        bus.result = bus.acc | src;
        bus.z_we   = 1'b1;
        bus.to_acc = 1'b1;
      end
      mcuex_pkg::op_or_mem_acc: begin
        bus.result = bus.acc | src;
        bus.z_we   = 1'b1;
        bus.to_mem = 1'b1;
      end
      mcuex_pkg::op_xor_acc_mem, mcuex_pkg::op_xor_acc_imm: begin
        bus.result = bus.acc ^ src;
        bus.z_we   = 1'b1;
        bus.to_acc = 1'b1;
      end
      mcuex_pkg::op_xor_mem_acc: begin
        bus.result = bus.acc ^ src;
        bus.z_we   = 1'b1;
        bus.to_mem = 1'b1;
      end
      mcuex_pkg::op_nibble_exchange_op: begin
        bus.result = {bus.mem[3:0], bus.mem[7:4]};
        bus.to_acc = 1'b1;
      end
      mcuex_pkg::op_nibble_exchange_in_place_op: begin
        bus.result = {bus.mem[3:0], bus.mem[7:4]};
        bus.to_mem = 1'b1;
      end
      mcuex_pkg::op_rotate_right_op,
      mcuex_pkg::op_rotate_right_in_place_op: begin
        bus.result = {bus.carry, bus.mem[7:1]};
        bus.c_out  = bus.mem[0];
        bus.c_we   = 1'b1;
        bus.to_acc = (bus.op == mcuex_pkg::op_rotate_right_op);
        bus.to_mem = (bus.op != mcuex_pkg::op_rotate_right_op);
      end
      mcuex_pkg::op_rotate_left_op,
      mcuex_pkg::op_rotate_left_in_place_op: begin
        bus.result = {bus.mem[6:0], bus.carry};
        bus.c_out  = bus.mem[7];
        bus.c_we   = 1'b1;
        bus.to_acc = (bus.op == mcuex_pkg::op_rotate_left_op);
        bus.to_mem = (bus.op != mcuex_pkg::op_rotate_left_op);
      end
      mcuex_pkg::op_clear_op: begin
        bus.result = 8'h00;
        bus.to_mem = 1'b1;
      end
      mcuex_pkg::op_bit_clear_op, mcuex_pkg::op_bank0_bit_clear_op: begin
        bus.result = bus.mem & ~mask;
        bus.to_mem = 1'b1;
      end
      mcuex_pkg::op_bit_set_op, mcuex_pkg::op_bank0_bit_set_op: begin
        bus.result = bus.mem | mask;
        bus.to_mem = 1'b1;
      end
      mcuex_pkg::op_compare_skip_imm, mcuex_pkg::op_compare_skip_mem: begin
        bus.result = diff[7:0];
        bus.c_out  = ~diff[8];  // No borrow leaves carry set
        bus.c_we   = 1'b1;
        bus.z_we   = 1'b1;
        bus.skip   = (bus.acc == src);
      end
      mcuex_pkg::op_increment_skip_op,
      mcuex_pkg::op_increment_memory_skip_op: begin
        bus.result = bus.mem + 8'h01;
        bus.skip   = (bus.mem == 8'hFF);
        bus.to_acc = (bus.op == mcuex_pkg::op_increment_skip_op);
        bus.to_mem = (bus.op != mcuex_pkg::op_increment_skip_op);
      end
      mcuex_pkg::op_decrement_skip_op,
      mcuex_pkg::op_decrement_memory_skip_op: begin
        bus.result = bus.mem - 8'h01;
        bus.skip   = (bus.mem == 8'h01);
        bus.to_acc = (bus.op == mcuex_pkg::op_decrement_skip_op);
        bus.to_mem = (bus.op != mcuex_pkg::op_decrement_skip_op);
      end
      mcuex_pkg::op_bit_zero_skip_op, mcuex_pkg::op_bank0_bit_zero_skip_op:
        bus.skip = ~bus.mem[bus.bit_sel];
      mcuex_pkg::op_bit_one_skip_op, mcuex_pkg::op_bank0_bit_one_skip_op:
        bus.skip = bus.mem[bus.bit_sel];
      default: begin
        bus.result = bus.acc;
      end
    endcase
  end

  assign bus.z_out = (bus.result == 8'h00);

endmodule

/* File: hw/mcuex_core.sv */
// Execute tail of the 8-bit CPU: logic, rotate, bit, skip, branch, stack.
// Assumes fetch presents one decoded instruction with its operand byte
// already read, from bank zero for the bank-zero forms.
//
// Notes on behaviour
// - Memory write-back costs one extra cycle for RAM except for clear, none for system registers.
// - A taken skip costs one extra cycle; the next instruction is discarded.
// - OR and XOR combine accumulator with memory or immediate; only zero flag changes.
// - Nibble swap loads accumulator with swapped memory byte, no flags, one cycle.
// - In-place nibble swap rewrites memory byte, no flags, one cycle plus RAM.
// - Compare sets zero and carry from the difference, skips when equal.
// - Increment memory into accumulator or memory, skip on zero, no flags.
// - Decrement memory into accumulator or memory, skip on zero, no flags.
// - Bit tests skip on bit zero or bit one, no flags changed.
// - Bank-zero bit forms address bank zero whatever the bank selection.
// - Jump takes page bits high and address field low, two cycles.
// - Call pushes the full program counter, then jumps like a jump.
// - Return pops the counter in two cycles; interrupt return also enables interrupts.
// - Push saves accumulator and flags to shadow buffers, one cycle.
// - Pop restores accumulator, carry, decimal carry, zero; timeout and power-down kept.
`timescale 1ns/1ps
`include "mcuex_map.svh"
module mcuex_core #(
  parameter int STACK_DEPTH = 8,
  parameter int ADDR_W      = 9
) (
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_arst_n,
  // Decoded instruction
  input  wire logic              i_op_valid,
  input  wire logic [5:0]        i_op,
  input  wire logic [7:0]        i_operand,
  input  wire logic              i_operand_is_sysreg,
  input  wire logic [ADDR_W-1:0] i_operand_addr,
  input  wire logic [1:0]        i_bank_sel,
  input  wire logic [7:0]        i_imm,
  input  wire logic [2:0]        i_bit_sel,
  input  wire logic [13:0]       i_target,
  // Status bits owned elsewhere
  input  wire logic              i_watchdog_timeout_flag,
  input  wire logic              i_power_down_flag,
  // Register port
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic [7:0]        i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic      [7:0]        o_reg_rdata,
  // Memory write-back
  output logic                   o_wr_en,
  output logic      [ADDR_W-1:0] o_wr_addr,
  output logic      [1:0]        o_wr_bank,
  output logic      [7:0]        o_wr_data,
  // Core state
  output logic                   o_ready,
  output logic                   o_discard_next,
  output logic      [15:0]       o_pc,
  output logic      [7:0]        o_acc,
  output logic      [2:0]        o_flags,
  output logic                   o_gie
);

  localparam int SP_W = $clog2(STACK_DEPTH);

  mcuex_alu_if alu_bus ();

  mcuex_alu u_alu (
    .bus (alu_bus)
  );

  logic [7:0]  acc_ff;
  logic        c_ff;
  logic        dc_ff;
  logic        z_ff;
  logic [7:0]  acc_shadow_ff;
  logic [2:0]  flag_shadow_ff;
  logic [15:0] pc_ff;
  logic [15:0] stack_mem [STACK_DEPTH];
  logic [SP_W-1:0] sp_ff;
  logic [1:0]  page_ff;
  logic        gie_ff;
  logic [1:0]  stall_ff;
  logic        ready_ff;
  logic        discard_ff;
  logic        wr_en_ff;
  logic [ADDR_W-1:0] wr_addr_ff;
  logic [1:0]  wr_bank_ff;
  logic [7:0]  wr_data_ff;
  logic [7:0]  rdata_ff;

  mcuex_pkg::mcuex_op_t op;
  logic        take;
  logic        is_branch;
  logic        is_bank0;
  logic        ram_write;
  logic [1:0]  nxt_stall;
  logic [SP_W-1:0] sp_top;
  logic [7:0]  flag_byte;

  always_comb begin
    op        = mcuex_pkg::mcuex_op_t'(i_op);
    take      = i_op_valid && ready_ff;
    is_branch = (op == mcuex_pkg::op_jump) ||
                (op == mcuex_pkg::op_call) ||
                (op == mcuex_pkg::op_return) ||
                (op == mcuex_pkg::op_interrupt_return_op);
    is_bank0  = (op == mcuex_pkg::op_bank0_bit_clear_op) ||
                (op == mcuex_pkg::op_bank0_bit_set_op) ||
                (op == mcuex_pkg::op_bank0_bit_zero_skip_op) ||
                (op == mcuex_pkg::op_bank0_bit_one_skip_op);
    ram_write = alu_bus.to_mem && !i_operand_is_sysreg;
    sp_top    = sp_ff - SP_W'(1);
    // Clear needs no read, so it stays one cycle even on RAM
    if (is_branch) begin
      nxt_stall = `MCUEX_EXTRA_BRANCH;
    end else begin
      nxt_stall = 2'((ram_write && op != mcuex_pkg::op_clear_op) ? 1 : 0)
                + 2'(alu_bus.skip ? 1 : 0);
    end
    flag_byte = 8'h00;
    flag_byte[`MCUEX_FLAG_C_BIT]  = c_ff;
    flag_byte[`MCUEX_FLAG_DC_BIT] = dc_ff;
    flag_byte[`MCUEX_FLAG_Z_BIT]  = z_ff;
    flag_byte[`MCUEX_FLAG_PD_BIT] = i_power_down_flag;
    flag_byte[`MCUEX_FLAG_TO_BIT] = i_watchdog_timeout_flag;
  end

  always_comb begin
    alu_bus.op      = op;
    alu_bus.acc     = acc_ff;
    alu_bus.mem     = i_operand;
    alu_bus.imm     = i_imm;
    alu_bus.bit_sel = i_bit_sel;
    alu_bus.carry   = c_ff;
  end

  // Accumulator and flags
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc_ff <= `MCUEX_RST_BYTE;
      c_ff   <= 1'b0;
      dc_ff  <= 1'b0;
      z_ff   <= 1'b0;
    end else if (take) begin
      if (op == mcuex_pkg::op_pop) begin
        acc_ff <= acc_shadow_ff;
        c_ff   <= flag_shadow_ff[`MCUEX_FLAG_C_BIT];
        dc_ff  <= flag_shadow_ff[`MCUEX_FLAG_DC_BIT];
        z_ff   <= flag_shadow_ff[`MCUEX_FLAG_Z_BIT];
      end else begin
        if (alu_bus.to_acc) begin
          acc_ff <= alu_bus.result;
        end
        if (alu_bus.c_we) begin
          c_ff <= alu_bus.c_out;
        end
        if (alu_bus.z_we) begin
          z_ff <= alu_bus.z_out;
        end
      end
    end
  end

  // Shadow buffers; timeout and power-down live elsewhere and stay out
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc_shadow_ff  <= `MCUEX_RST_BYTE;
      flag_shadow_ff <= 3'h0;
    end else if (take && op == mcuex_pkg::op_push) begin
      acc_shadow_ff  <= acc_ff;
      flag_shadow_ff <= flag_byte[2:0];
    end
  end

  // Program counter and hardware stack
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pc_ff <= `MCUEX_RST_PC;
      sp_ff <= '0;
    end else if (take) begin
      case (op)
        mcuex_pkg::op_jump: begin
          pc_ff <= {page_ff, i_target};
        end
        mcuex_pkg::op_call: begin
          pc_ff <= {page_ff, i_target};
          sp_ff <= sp_ff + SP_W'(1);
        end
        mcuex_pkg::op_return, mcuex_pkg::op_interrupt_return_op: begin
          pc_ff <= stack_mem[sp_top];
          sp_ff <= sp_top;
        end
        default: begin
          pc_ff <= pc_ff + (alu_bus.skip ? 16'h0002 : 16'h0001);
        end
      endcase
    end
  end

  // Return address is the counter of the next instruction; overflow wraps
  always_ff @(posedge i_clock) begin
    if (take && op == mcuex_pkg::op_call) begin
      stack_mem[sp_ff] <= pc_ff + 16'h0001;
    end
  end

  // Cycle accounting: ready drops for the extra cycles
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stall_ff   <= `MCUEX_EXTRA_NONE;
      ready_ff   <= 1'b1;
      discard_ff <= 1'b0;
    end else if (take) begin
      stall_ff   <= nxt_stall;
      ready_ff   <= (nxt_stall == `MCUEX_EXTRA_NONE);
      discard_ff <= alu_bus.skip && !is_branch;
    end else begin
      discard_ff <= 1'b0;
      if (stall_ff != `MCUEX_EXTRA_NONE) begin
        stall_ff <= stall_ff - 2'h1;
        ready_ff <= (stall_ff == 2'h1);
      end
    end
  end

  // Memory write-back
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_en_ff   <= 1'b0;
      wr_addr_ff <= '0;
      wr_bank_ff <= 2'h0;
      wr_data_ff <= `MCUEX_RST_BYTE;
    end else begin
      wr_en_ff <= take && alu_bus.to_mem;
      if (take && alu_bus.to_mem) begin
        wr_addr_ff <= i_operand_addr;
        wr_bank_ff <= is_bank0 ? 2'h0 : i_bank_sel;
        wr_data_ff <= alu_bus.result;
      end
    end
  end

  // Control bits; interrupt return wins over a software clear
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      page_ff <= `MCUEX_RST_PAGE;
      gie_ff  <= 1'b0;
    end else begin
      if (i_reg_wr && i_reg_addr == `MCUEX_OFS_CTRL) begin
        page_ff <= i_reg_wdata[`MCUEX_CTRL_PAGE_MSB:`MCUEX_CTRL_PAGE_LSB];
        gie_ff  <= i_reg_wdata[`MCUEX_CTRL_GIE_BIT];
      end
      if (take && op == mcuex_pkg::op_interrupt_return_op) begin
        gie_ff <= 1'b1;
      end
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_ff <= `MCUEX_RST_BYTE;
    end else if (i_reg_rd) begin
      if (i_reg_addr == `MCUEX_OFS_CTRL) begin
        rdata_ff <= {5'h00, gie_ff, page_ff};
      end else if (i_reg_addr == `MCUEX_OFS_FLAGS) begin
        rdata_ff <= flag_byte;
      end else if (i_reg_addr == `MCUEX_OFS_ACC) begin
        rdata_ff <= acc_ff;
      end else if (i_reg_addr == `MCUEX_OFS_PC_LO) begin
        rdata_ff <= pc_ff[7:0];
      end else if (i_reg_addr == `MCUEX_OFS_PC_HI) begin
        rdata_ff <= pc_ff[15:8];
      end else begin
        rdata_ff <= `MCUEX_RST_BYTE;
      end
    end else begin
      rdata_ff <= `MCUEX_RST_BYTE;
    end
  end

  assign o_reg_rdata    = rdata_ff;
  assign o_wr_en        = wr_en_ff;
  assign o_wr_addr      = wr_addr_ff;
  assign o_wr_bank      = wr_bank_ff;
  assign o_wr_data      = wr_data_ff;
  assign o_ready        = ready_ff;
  assign o_discard_next = discard_ff;
  assign o_pc           = pc_ff;
  assign o_acc          = acc_ff;
  assign o_flags        = {z_ff, dc_ff, c_ff};
  assign o_gie          = gie_ff;

endmodule

/* File: verification/mcuex_core_checker.sv */
// Checker for the execute tail core, bound to its top-level ports.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
module mcuex_core_checker (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_arst_n,
  // Instruction side
  input  wire logic        i_op_valid,
  input  wire logic [5:0]  i_op,
  input  wire logic [7:0]  i_operand,
  input  wire logic        i_operand_is_sysreg,
  input  wire logic [7:0]  i_imm,
  input  wire logic [2:0]  i_bit_sel,
  input  wire logic [13:0] i_target,
  // Core state
  input  wire logic        o_wr_en,
  input  wire logic [1:0]  o_wr_bank,
  input  wire logic [7:0]  o_wr_data,
  input  wire logic        o_ready,
  input  wire logic        o_discard_next,
  input  wire logic [15:0] o_pc,
  input  wire logic [7:0]  o_acc,
  input  wire logic [2:0]  o_flags,
  input  wire logic        o_gie
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  wire tk = i_op_valid && o_ready;

  skip_stall_a: assert property (o_discard_next |-> !o_ready)
    else $error("Ready high during skip");
  jump_target_a: assert property (tk && i_op == mcuex_pkg::op_jump
    |=> o_pc[13:0] == $past(i_target) && !o_ready ##1 o_ready)
    else $error("Jump target or timing wrong");
  call_target_a: assert property (tk && i_op == mcuex_pkg::op_call
    |=> o_pc[13:0] == $past(i_target) && !o_ready ##1 o_ready)
    else $error("Call target or timing wrong");
  return_time_a: assert property (tk &&
    (i_op == mcuex_pkg::op_return ||
     i_op == mcuex_pkg::op_interrupt_return_op) |=> !o_ready ##1 o_ready)
    else $error("Return not two cycles");
  return_gie_a: assert property (tk &&
    i_op == mcuex_pkg::op_interrupt_return_op |=> o_gie)
    else $error("Interrupt return left enable low");
  or_imm_zero_a: assert property (tk &&
    i_op == mcuex_pkg::op_or_acc_imm |=>
    o_acc == ($past(o_acc) | $past(i_imm)) &&
    o_flags == {o_acc == 8'h00, 2'($past(o_flags))})
    else $error("OR immediate result or flags wrong");
  swap_acc_a: assert property (tk &&
    i_op == mcuex_pkg::op_nibble_exchange_op |=>
    o_acc == {<<4{$past(i_operand)}} && $stable(o_flags) && o_ready)
    else $error("Nibble swap to accumulator wrong");
  compare_eq_a: assert property (tk &&
    i_op == mcuex_pkg::op_compare_skip_imm |=>
    o_flags[2] == ($past(o_acc) == $past(i_imm)) &&
    o_discard_next == o_flags[2])
    else $error("Compare zero or skip wrong");
  ram_writeback_a: assert property (tk &&
    i_op == mcuex_pkg::op_or_mem_acc && !i_operand_is_sysreg |=>
    o_wr_en && !o_ready ##1 o_ready)
    else $error("RAM write-back timing wrong");
  clear_once_a: assert property (tk &&
    i_op == mcuex_pkg::op_clear_op |=>
    o_wr_en && o_wr_data == 8'h00 && o_ready)
    else $error("Clear wrong");
  bank0_set_a: assert property (tk &&
    i_op == mcuex_pkg::op_bank0_bit_set_op |=>
    o_wr_bank == 2'h0 && o_wr_data[$past(i_bit_sel)])
    else $error("Bank zero bit set wrong");

  cover property (tk && i_op == mcuex_pkg::op_call);
  cover property (o_discard_next);
  cover property (tk && i_op == mcuex_pkg::op_pop);
endmodule

bind mcuex_core mcuex_core_checker u_chk (
  .i_clock, .i_arst_n, .i_op_valid, .i_op, .i_operand, .i_operand_is_sysreg,
  .i_imm, .i_bit_sel, .i_target, .o_wr_en, .o_wr_bank, .o_wr_data, .o_ready,
  .o_discard_next, .o_pc, .o_acc, .o_flags, .o_gie
);

/* File: verification/testbench.sv */
// Self-checking bench for the execute tail core.
// Assumes the bench drives every core input itself.
`timescale 1ns/1ps
`include "mcuex_map.svh"
module testbench;
  logic        i_clock, i_arst_n, i_op_valid, i_operand_is_sysreg;
  logic [5:0]  i_op;
  logic [7:0]  i_operand, i_imm, i_reg_addr, i_reg_wdata;
  logic [8:0]  i_operand_addr;
  logic [1:0]  i_bank_sel, o_wr_bank, page_m;
  logic [2:0]  i_bit_sel, o_flags, f_m, sf_m;
  logic [13:0] i_target;
  logic        i_watchdog_timeout_flag, i_power_down_flag, i_reg_wr;
  logic        i_reg_rd, o_wr_en, o_ready, o_discard_next, o_gie, gie_m;
  logic [7:0]  o_reg_rdata, o_wr_data, o_acc, a_m, sa_m;
  logic [8:0]  o_wr_addr;
  logic [15:0] o_pc, pc_m;
  logic [15:0] stk[$];
  logic [7:0]  opds[5] = '{8'hFF, 8'h01, 8'h5A, 8'h80, 8'h00};
  int          fail_count = 0, n_tests = 0, cyc = 0;

  mcuex_core i_dut (.i_clock, .i_arst_n, .i_op_valid, .i_op, .i_operand,
    .i_operand_is_sysreg, .i_operand_addr, .i_bank_sel, .i_imm, .i_bit_sel,
    .i_target, .i_watchdog_timeout_flag, .i_power_down_flag, .i_reg_addr,
    .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_wr_en, .o_wr_addr,
    .o_wr_bank, .o_wr_data, .o_ready, .o_discard_next, .o_pc, .o_acc,
    .o_flags, .o_gie);

  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs about 400 cycles
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic reg_wr(input logic [7:0] ad, d);
    @(posedge i_clock);
    i_reg_wr    <= 1'b1;
    i_reg_addr  <= ad;
    i_reg_wdata <= d;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] ad, e);
    @(posedge i_clock);
    i_reg_rd   <= 1'b1;
    i_reg_addr <= ad;
    @(posedge i_clock);
    i_reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", e, o_reg_rdata);
  endtask

  // Model, then one instruction, then outputs and stall
  task automatic ex(input mcuex_pkg::mcuex_op_t op, input logic [7:0] m, imm,
                    input logic sr);
    logic        ta, wr, uz, s, br, b0;
    logic [7:0]  r;
    logic [10:0] q;
    logic [2:0]  b;
    logic [13:0] t;
    logic [15:0] pc_n;
    int          e, n;
    b = m[6:4];
    t = {m[5:0], m};
    {s, br} = 2'h0;
    b0 = op inside {mcuex_pkg::op_bank0_bit_set_op,
      mcuex_pkg::op_bank0_bit_clear_op};
    case (op)
      mcuex_pkg::op_or_acc_mem: q = {3'h5, a_m | m};
      mcuex_pkg::op_or_mem_acc: q = {3'h3, a_m | m};
      mcuex_pkg::op_or_acc_imm: q = {3'h5, a_m | imm};
      mcuex_pkg::op_xor_acc_mem: q = {3'h5, a_m ^ m};
      mcuex_pkg::op_xor_mem_acc: q = {3'h3, a_m ^ m};
      mcuex_pkg::op_xor_acc_imm: q = {3'h5, a_m ^ imm};
      mcuex_pkg::op_nibble_exchange_op: q = {3'h4, m[3:0], m[7:4]};
      mcuex_pkg::op_nibble_exchange_in_place_op: q = {3'h2, m[3:0], m[7:4]};
      mcuex_pkg::op_rotate_right_op: q = {3'h4, f_m[0], m[7:1]};
      mcuex_pkg::op_rotate_right_in_place_op: q = {3'h2, f_m[0], m[7:1]};
      mcuex_pkg::op_rotate_left_op: q = {3'h4, m[6:0], f_m[0]};
      mcuex_pkg::op_rotate_left_in_place_op: q = {3'h2, m[6:0], f_m[0]};
      mcuex_pkg::op_clear_op: q = {3'h2, 8'h00};
      mcuex_pkg::op_bit_clear_op, mcuex_pkg::op_bank0_bit_clear_op:
        q = {3'h2, m & ~(8'h01 << b)};
      mcuex_pkg::op_bit_set_op, mcuex_pkg::op_bank0_bit_set_op:
        q = {3'h2, m | (8'h01 << b)};
      mcuex_pkg::op_increment_skip_op: q = {3'h4, m + 8'h01};
      mcuex_pkg::op_increment_memory_skip_op: q = {3'h2, m + 8'h01};
      mcuex_pkg::op_decrement_skip_op: q = {3'h4, m - 8'h01};
      mcuex_pkg::op_decrement_memory_skip_op: q = {3'h2, m - 8'h01};
      default: q = {3'h0, m};
    endcase
    {ta, wr, uz, r} = q;
    case (op)
      mcuex_pkg::op_compare_skip_imm: {s, f_m[2], f_m[0]} =
        {a_m == imm, a_m == imm, a_m >= imm};
      mcuex_pkg::op_compare_skip_mem: {s, f_m[2], f_m[0]} =
        {a_m == m, a_m == m, a_m >= m};
      mcuex_pkg::op_increment_skip_op, mcuex_pkg::op_decrement_skip_op,
      mcuex_pkg::op_increment_memory_skip_op,
      mcuex_pkg::op_decrement_memory_skip_op: s = (r == 8'h00);
      mcuex_pkg::op_bit_zero_skip_op, mcuex_pkg::op_bank0_bit_zero_skip_op:
        s = !m[b];
      mcuex_pkg::op_bit_one_skip_op, mcuex_pkg::op_bank0_bit_one_skip_op:
        s = m[b];
      mcuex_pkg::op_rotate_right_op, mcuex_pkg::op_rotate_right_in_place_op:
        f_m[0] = m[0];
      mcuex_pkg::op_rotate_left_op, mcuex_pkg::op_rotate_left_in_place_op:
        f_m[0] = m[7];
      mcuex_pkg::op_push: {sa_m, sf_m} = {a_m, f_m};
      mcuex_pkg::op_pop: {a_m, f_m} = {sa_m, sf_m};
      mcuex_pkg::op_jump: {br, pc_n} = {1'b1, page_m, t};
      mcuex_pkg::op_call: begin
        stk.push_back(pc_m + 16'h0001);
        {br, pc_n} = {1'b1, page_m, t};
      end
      mcuex_pkg::op_return: {br, pc_n} = {1'b1, stk.pop_back()};
      mcuex_pkg::op_interrupt_return_op: begin
        {br, pc_n} = {1'b1, stk.pop_back()};
        gie_m = 1'b1;
      end
      default: ;
    endcase
    if (ta)
      a_m = r;
    if (uz)
      f_m[2] = (r == 8'h00);
    if (!br)
      pc_n = pc_m + (s ? 16'h0002 : 16'h0001);
    pc_m = pc_n;
    e = br ? 1 : int'(wr && !sr && op != mcuex_pkg::op_clear_op) + int'(s);
    @(posedge i_clock);
    i_op_valid          <= 1'b1;
    i_op                <= op;
    i_operand           <= m;
    i_imm               <= imm;
    i_operand_is_sysreg <= sr;
    i_bit_sel           <= b;
    i_target            <= t;
    i_bank_sel          <= m[7:6];
    i_operand_addr      <= {1'b1, m};
    @(posedge i_clock);
    i_op_valid <= 1'b0;
    #1;
    chk("acc", a_m, o_acc);
    chk("flags", f_m, o_flags);
    chk("pc", pc_m, o_pc);
    chk("wr_en", wr, o_wr_en);
    if (wr) begin
      chk("wr_data", r, o_wr_data);
      chk("wr_addr", {1'b1, m}, o_wr_addr);
      chk("wr_bank", b0 ? 2'h0 : m[7:6], o_wr_bank);
    end
    chk("discard", s, o_discard_next);
    n = 0;
    while (o_ready !== 1'b1 && n < 4) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    chk("stall", e, n);
  endtask

  initial begin
    {i_arst_n, i_op_valid, i_op, i_operand, i_operand_is_sysreg} = '0;
    {i_operand_addr, i_bank_sel, i_imm, i_bit_sel, i_target} = '0;
    {i_reg_addr, i_reg_wdata, i_reg_wr, i_reg_rd} = '0;
    {i_watchdog_timeout_flag, i_power_down_flag} = 2'h3;
    {a_m, sa_m, f_m, sf_m, pc_m, page_m, gie_m} = '0;
    repeat (10) @(posedge i_clock);
    i_arst_n <= 1'b1;
    reg_rd(`MCUEX_OFS_CTRL, 8'h00);
    reg_rd(`MCUEX_OFS_FLAGS, 8'h30);
    reg_wr(`MCUEX_OFS_ACC, 8'hFF);
    reg_rd(`MCUEX_OFS_ACC, 8'h00);
    reg_rd(8'h10, 8'h00);
    reg_wr(`MCUEX_OFS_CTRL, 8'h02);
    page_m = 2'h2;
    reg_rd(`MCUEX_OFS_CTRL, 8'h02);
    // Every non-branch code, operands chosen to hit both skip outcomes
    for (int j = 0; j < 5; j++)
      for (int k = 0; k < 34; k++)
        if (!(k inside {[28:31]}))
          ex(mcuex_pkg::mcuex_op_t'(k), opds[j], 8'h3C, j[0]);
    ex(mcuex_pkg::op_xor_acc_imm, 8'h00, a_m, 1'b1);
    ex(mcuex_pkg::op_push, 8'h00, 8'h00, 1'b0);
    ex(mcuex_pkg::op_or_acc_imm, 8'h00, 8'hA5, 1'b0);
    ex(mcuex_pkg::op_pop, 8'h00, 8'h00, 1'b0);
    ex(mcuex_pkg::op_compare_skip_imm, 8'h00, 8'h00, 1'b0);
    ex(mcuex_pkg::op_compare_skip_mem, 8'h01, 8'h00, 1'b0);
    ex(mcuex_pkg::op_call, 8'h9D, 8'h00, 1'b0);
    ex(mcuex_pkg::op_call, 8'h42, 8'h00, 1'b0);
    ex(mcuex_pkg::op_return, 8'h00, 8'h00, 1'b0);
    ex(mcuex_pkg::op_interrupt_return_op, 8'h00, 8'h00, 1'b0);
    ex(mcuex_pkg::op_jump, 8'hE7, 8'h00, 1'b0);
    chk("gie", gie_m, o_gie);
    reg_rd(`MCUEX_OFS_CTRL, {5'h00, gie_m, page_m});
    reg_rd(`MCUEX_OFS_FLAGS, {5'h06, f_m});
    reg_rd(`MCUEX_OFS_ACC, a_m);
    reg_rd(`MCUEX_OFS_PC_LO, pc_m[7:0]);
    reg_rd(`MCUEX_OFS_PC_HI, pc_m[15:8]);
    results();
  end
endmodule
